//--- logic/t1_cond_pkg.sv
// constants and carrier types for the t1 fault conditioning block
//
// What this block does
// - red alarm held 1 s or 10 s before recovery; 1 s default.
// - unused timeslots toward the line carry the idle byte, default 7E, framed only.
// - signalling enabled puts the framer in CAS in framed modes, fractional with signalling; default.
// - signalling disabled leaves the framer out of CAS, plain fractional.
// - during faults affected timeslots carry the conditioning byte, default 7F.
// - line loss of signal, and in framed modes loss of frame or AIS, conditions data toward the packet side.
// - packet buffer overrun or underrun conditions data toward the line.
// - unframed conditioning sends AIS, from line LOS or buffer overrun/underrun.
// - during faults signalling bits forced to a code 1..F, default 1.
// - line loss of signal, frame or AIS conditions signalling toward the packet side.
// - buffer overrun or underrun conditions signalling toward the line.
// - AIS on the line is an unframed all-ones stream.
package t1_cond_pkg;

    // ****************************************
    // line types and defaults
    // ****************************************
    typedef enum logic [1:0] {
        LINE_D4 = 2'b00,
        LINE_ESF = 2'b01,
        LINE_UNFRAMED = 2'b10
    } line_type;

    localparam logic [7:0] IDLE_DEFAULT = 8'h7E;
    localparam logic [7:0] COND_DATA_DEFAULT = 8'h7F;
    localparam logic [3:0] COND_SIG_DEFAULT = 4'h1;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [3:0] SIG_AB_MASK = 4'h3;
    localparam logic [4:0] SLOT_LAST = 5'h17;
    localparam logic [4:0] SLOT_FIRST = 5'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLOCK_MHZ = 250;
    localparam int RESTORE_SHORT_S = 1;
    localparam int RESTORE_LONG_S = 10;
    localparam longint RESTORE_SHORT_CYC = longint'(RESTORE_SHORT_S) * CLOCK_MHZ * 1000000;
    localparam longint RESTORE_LONG_CYC = longint'(RESTORE_LONG_S) * CLOCK_MHZ * 1000000;
    localparam int FIFO_DEPTH = 16;
    localparam int SLOT_W = 13;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [4:0] slot;
        logic [3:0] sig;
        logic [7:0] data;
    } slot_word_type;

    typedef struct packed {
        logic los;
        logic lof;
        logic ais;
    } line_alarm_type;

    typedef struct packed {
        line_type line_mode;
        logic cas_enable;
        logic restore_long;
        logic [7:0] idle_code;
        logic [7:0] cond_data;
        logic [3:0] cond_sig;
    } config_type;

endpackage : t1_cond_pkg

//--- logic/slot_fifo.sv
// small synchronous fifo for timeslot words
module slot_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    input wire logic mclk, // clock
    input wire logic reset, // sync reset, high
    input wire logic [WIDTH-1:0] in_data, // write word
    input wire logic in_valid, // write request
    output logic in_ready, // room available
    output logic [WIDTH-1:0] out_data, // read word
    output logic out_valid, // word available
    input wire logic out_ready // read accept
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    // honest flags straight from the occupancy
    assign in_ready = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (count != '0);
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // storage
    always_ff @(posedge mclk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            if (do_wr && !do_rd) begin
                count <= count + (AW+1)'(1);
            end else if (do_rd && !do_wr) begin
                count <= count - (AW+1)'(1);
            end
        end
    end
endmodule : slot_fifo

//--- logic/t1_fault_conditioning.sv
// idle insertion toward the line and fault conditioning in both directions for one t1 port
module t1_fault_conditioning
    import t1_cond_pkg::*;
#(
    parameter longint RESTORE_SHORT = RESTORE_SHORT_CYC, // 1 s of mclk
    parameter longint RESTORE_LONG = RESTORE_LONG_CYC // 10 s of mclk
) (
    input wire logic mclk, // 250 MHz clock
    input wire logic reset, // sync reset, high
    input wire config_type cfg, // configuration levels
    input wire line_alarm_type line_alarm_pin, // line alarms, async
    input wire logic buf_overrun, // packet buffer overrun level
    input wire logic buf_underrun, // packet buffer underrun level
    input wire logic slot_used, // current line slot assigned
    input wire slot_word_type pkt_word, // word from packet path
    input wire logic pkt_valid, // packet word valid
    output logic pkt_ready, // packet side may send
    output slot_word_type line_word, // word toward t1 line
    output logic line_valid, // line word valid
    input wire logic line_ready, // line side takes word
    input wire slot_word_type rx_word, // word from t1 line
    input wire logic rx_valid, // line word valid (strobe)
    output slot_word_type ip_word, // word toward packet side
    output logic ip_valid, // packet word valid
    output logic framer_cas, // framer in cas mode
    output logic framer_framed, // framer framed, not passthrough
    output logic red_alarm, // red alarm incl. restore hold
    output logic cond_to_line, // conditioning toward line
    output logic cond_to_ip // conditioning toward packet
);
    // ****************************************
    // alarm synchronisers
    // ****************************************
    line_alarm_type alarm_meta;
    line_alarm_type alarm_sync;

    // line alarms come from another domain: two flops before use
    always_ff @(posedge mclk) begin
        if (reset) begin
            alarm_meta <= '0;
            alarm_sync <= '0;
        end else begin
            alarm_meta <= line_alarm_pin;
            alarm_sync <= alarm_meta;
        end
    end

    logic line_fault;
    logic framed;
    logic buf_fault;
    assign framed = (cfg.line_mode != LINE_UNFRAMED);
    // unframed watches only los; framed also frame loss and ais
    assign line_fault = alarm_sync.los || (framed && (alarm_sync.lof || alarm_sync.ais));
    assign buf_fault = buf_overrun || buf_underrun;

    // ****************************************
    // red alarm and restore timer
    // ****************************************
    logic [35:0] restore_count;
    logic [35:0] restore_target;
    // counter wide enough for ten seconds at 250 MHz
    assign restore_target = cfg.restore_long ? 36'(RESTORE_LONG) : 36'(RESTORE_SHORT);

    // alarm rises at once; falls only after the fault stays gone a full restore time
    always_ff @(posedge mclk) begin
        if (reset) begin
            red_alarm <= 1'b0;
            restore_count <= '0;
        end else if (line_fault) begin
            red_alarm <= 1'b1;
            restore_count <= '0;
        end else if (red_alarm) begin
            if (restore_count >= restore_target - 36'(1)) begin
                red_alarm <= 1'b0;
                restore_count <= '0;
            end else begin
                restore_count <= restore_count + 36'(1);
            end
        end
    end

    // ****************************************
    // framer mode
    // ****************************************
    // cas only makes sense with framing; unframed is plain passthrough
    always_ff @(posedge mclk) begin
        if (reset) begin
            framer_cas <= 1'b1;
            framer_framed <= 1'b1;
        end else begin
            framer_cas <= framed && cfg.cas_enable;
            framer_framed <= framed;
        end
    end

    // ****************************************
    // packet to line path through the fifo
    // ****************************************
    slot_word_type fifo_out;
    logic fifo_valid;
    logic fifo_take;

    slot_fifo #(
        .WIDTH($bits(slot_word_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .in_data(pkt_word),
        .in_valid(pkt_valid),
        .in_ready(pkt_ready),
        .out_data(fifo_out),
        .out_valid(fifo_valid),
        .out_ready(fifo_take)
    );

    // an output word is free when empty or when the line takes it
    logic out_free;
    assign out_free = !line_valid || line_ready;
    // used slots, and every slot when unframed, consume fifo data; unused framed slots get idle without draining
    assign fifo_take = out_free && fifo_valid && (slot_used || !framed);

    // signalling forced code is width-limited to AB bits in d4
    function automatic logic [3:0] sig_code(input config_type c);
        sig_code = (c.line_mode == LINE_D4) ? (c.cond_sig & SIG_AB_MASK) : c.cond_sig;
    endfunction : sig_code

    logic [4:0] line_slot;
    assign cond_to_line = buf_fault;

    // toward the line: ais, idle, conditioning or live data
    always_ff @(posedge mclk) begin
        if (reset) begin
            line_word <= '0;
            line_valid <= 1'b0;
            line_slot <= SLOT_FIRST;
        end else if (out_free) begin
            if (!framed && buf_fault) begin
                line_word <= '{slot: SLOT_FIRST, sig: '1, data: ALL_ONES};
                line_valid <= 1'b1;
            end else if (framed && !slot_used) begin
                line_word <= '{slot: line_slot, sig: '0, data: cfg.idle_code};
                line_valid <= 1'b1;
                line_slot <= (line_slot == SLOT_LAST) ? SLOT_FIRST : line_slot + 5'(1);
            end else if (fifo_valid) begin
                line_word.slot <= fifo_out.slot;
                line_word.data <= buf_fault ? cfg.cond_data : fifo_out.data;
                line_word.sig <= (buf_fault && framer_cas) ? sig_code(cfg) : fifo_out.sig;
                line_valid <= 1'b1;
                line_slot <= (line_slot == SLOT_LAST) ? SLOT_FIRST : line_slot + 5'(1);
            end else begin
                line_valid <= 1'b0;
            end
        end
    end

    // ****************************************
    // line to packet path
    // ****************************************
    assign cond_to_ip = line_fault;

    // toward the packet side: conditioning replaces live data while the line is faulty
    always_ff @(posedge mclk) begin
        if (reset) begin
            ip_word <= '0;
            ip_valid <= 1'b0;
        end else begin
            ip_valid <= rx_valid;
            if (rx_valid) begin
                ip_word.slot <= rx_word.slot;
                ip_word.data <= line_fault ? (framed ? cfg.cond_data : ALL_ONES) : rx_word.data;
                ip_word.sig <= (line_fault && framer_cas) ? sig_code(cfg) : rx_word.sig;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_red_hold;
        @(posedge mclk) disable iff (reset)
        line_fault |=> red_alarm;
    endproperty
    a_red_hold: assert property (p_red_hold) else $error("red alarm not raised");

    property p_idle;
        @(posedge mclk) disable iff (reset)
        (out_free && framed && !slot_used) |=> (line_valid && line_word.data == $past(cfg.idle_code));
    endproperty
    a_idle: assert property (p_idle) else $error("idle byte missing");

    property p_cas_on;
        @(posedge mclk) disable iff (reset)
        (framed && cfg.cas_enable) |=> framer_cas;
    endproperty
    a_cas_on: assert property (p_cas_on) else $error("framer not in cas");

    property p_cas_off;
        @(posedge mclk) disable iff (reset)
        !cfg.cas_enable |=> !framer_cas;
    endproperty
    a_cas_off: assert property (p_cas_off) else $error("framer left in cas");

    property p_cond_ip;
        @(posedge mclk) disable iff (reset)
        (rx_valid && line_fault && framed) |=> (ip_valid && ip_word.data == $past(cfg.cond_data));
    endproperty
    a_cond_ip: assert property (p_cond_ip) else $error("packet side not conditioned");

    property p_cond_line;
        @(posedge mclk) disable iff (reset)
        (out_free && framed && slot_used && fifo_valid && buf_fault) |=>
            (line_word.data == $past(cfg.cond_data));
    endproperty
    a_cond_line: assert property (p_cond_line) else $error("line side not conditioned");

    property p_ais;
        @(posedge mclk) disable iff (reset)
        (out_free && !framed && buf_fault) |=> (line_valid && line_word.data == ALL_ONES);
    endproperty
    a_ais: assert property (p_ais) else $error("ais not sent");

    property p_live;
        @(posedge mclk) disable iff (reset)
        (rx_valid && !line_fault) |=> (ip_word.data == $past(rx_word.data));
    endproperty
    a_live: assert property (p_live) else $error("live data not passed");

    // ****************************************
    // further checks on both paths, the red alarm and the framer mode
    // ****************************************

    property p_sig_line_esf;
        @(posedge mclk) disable iff (reset)
        (out_free && slot_used && fifo_valid && buf_fault && framer_cas && cfg.line_mode == LINE_ESF) |=>
            (line_word.sig == $past(cfg.cond_sig));
    endproperty
    a_sig_line_esf: assert property (p_sig_line_esf) else $error("abcd code not forced toward line");

    // d4 carries only the two ab bits of the code
    property p_sig_line_d4;
        @(posedge mclk) disable iff (reset)
        (out_free && slot_used && fifo_valid && buf_fault && framer_cas && cfg.line_mode == LINE_D4) |=>
            (line_word.sig == ($past(cfg.cond_sig) & SIG_AB_MASK));
    endproperty
    a_sig_line_d4: assert property (p_sig_line_d4) else $error("ab code not forced toward line");

    property p_live_line;
        @(posedge mclk) disable iff (reset)
        (out_free && framed && slot_used && fifo_valid && !buf_fault) |=>
            (line_word.data == $past(fifo_out.data) && line_word.sig == $past(fifo_out.sig));
    endproperty
    a_live_line: assert property (p_live_line) else $error("live word not passed to line");

    // a refused word must stand, or the line would see a torn slot
    property p_line_stands;
        @(posedge mclk) disable iff (reset)
        (line_valid && !line_ready) |=> (line_valid && $stable(line_word));
    endproperty
    a_line_stands: assert property (p_line_stands) else $error("line word changed while refused");

    property p_ais_sig;
        @(posedge mclk) disable iff (reset)
        (out_free && !framed && buf_fault) |=> (line_word.sig == 4'hF);
    endproperty
    a_ais_sig: assert property (p_ais_sig) else $error("ais signalling bits not all ones");

    property p_sig_ip;
        @(posedge mclk) disable iff (reset)
        (rx_valid && line_fault && framer_cas && cfg.line_mode == LINE_ESF) |=> (ip_word.sig == $past(cfg.cond_sig));
    endproperty
    a_sig_ip: assert property (p_sig_ip) else $error("abcd code not forced toward packet side");

    property p_ais_ip;
        @(posedge mclk) disable iff (reset)
        (rx_valid && line_fault && !framed) |=> (ip_word.data == ALL_ONES);
    endproperty
    a_ais_ip: assert property (p_ais_ip) else $error("unframed fault not all ones");

    property p_live_sig_ip;
        @(posedge mclk) disable iff (reset)
        (rx_valid && !line_fault) |=> (ip_word.sig == $past(rx_word.sig));
    endproperty
    a_live_sig_ip: assert property (p_live_sig_ip) else $error("live signalling not passed");

    property p_ip_strobe;
        @(posedge mclk) disable iff (reset)
        !rx_valid |=> !ip_valid;
    endproperty
    a_ip_strobe: assert property (p_ip_strobe) else $error("packet word without line word");

    // the alarm must not drop before the restore time has run out
    property p_red_keep;
        @(posedge mclk) disable iff (reset)
        (red_alarm && !line_fault && restore_count < restore_target - 36'(1)) |=> red_alarm;
    endproperty
    a_red_keep: assert property (p_red_keep) else $error("red alarm dropped early");

    property p_red_clear;
        @(posedge mclk) disable iff (reset)
        (red_alarm && !line_fault && restore_count >= restore_target - 36'(1)) |=> !red_alarm;
    endproperty
    a_red_clear: assert property (p_red_clear) else $error("red alarm held too long");

    property p_unframed_mode;
        @(posedge mclk) disable iff (reset)
        !framed |=> (!framer_cas && !framer_framed);
    endproperty
    a_unframed_mode: assert property (p_unframed_mode) else $error("framer not in passthrough");

endmodule : t1_fault_conditioning

//--- verification/t1_line_model.sv
// t1 line side model: takes line words, promptly or with stalls
module t1_line_model
    import t1_cond_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic reset, // sync reset, high
    input wire slot_word_type line_word, // word from block
    input wire logic line_valid, // word offered
    output logic line_ready, // word taken
    input wire logic stall, // hold off the block
    input wire logic slow, // take every other cycle
    output slot_word_type got_word, // last word taken
    output int got_count // words taken
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // acceptance
    // ****************************************
    logic phase;
    // slow mode makes the block hold line_word across refused cycles
    always_comb line_ready = !stall && !(slow && phase);
    // capture only on the accepting edge
    always_ff @(posedge mclk) begin
        if (reset) begin
            phase <= 1'b0;
            got_count <= 0;
        end else begin
            phase <= !phase;
            if (line_valid && line_ready) begin
                got_word <= line_word;
                got_count <= got_count + 1;
            end
        end
    end
endmodule : t1_line_model

//--- verification/tb.sv
// self-checking bench for the t1 fault conditioning block
module tb
    import t1_cond_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // signals and instances
    // ****************************************
    localparam int SHORT_N = 20;
    localparam int LONG_N = 50;
    logic mclk = 0, reset = 1, buf_overrun = 0, buf_underrun = 0, slot_used = 0, pkt_valid = 0, rx_valid = 0;
    logic pkt_ready, line_valid, line_ready, ip_valid, framer_cas, framer_framed, red_alarm, cond_to_line, cond_to_ip;
    logic stall = 0, slow = 0;
    config_type cfg;
    line_alarm_type line_alarm_pin = '0;
    slot_word_type pkt_word = '0, rx_word = '0, line_word, ip_word, got_word, w;
    int got_count, mismatches = 0, compares = 0, cycles = 0, k, h;
    t1_fault_conditioning #(.RESTORE_SHORT(SHORT_N), .RESTORE_LONG(LONG_N)) t1_fault_conditioning_inst (
        .mclk(mclk), .reset(reset), .cfg(cfg), .line_alarm_pin(line_alarm_pin), .buf_overrun(buf_overrun),
        .buf_underrun(buf_underrun), .slot_used(slot_used), .pkt_word(pkt_word), .pkt_valid(pkt_valid),
        .pkt_ready(pkt_ready), .line_word(line_word), .line_valid(line_valid), .line_ready(line_ready),
        .rx_word(rx_word), .rx_valid(rx_valid), .ip_word(ip_word), .ip_valid(ip_valid), .framer_cas(framer_cas),
        .framer_framed(framer_framed), .red_alarm(red_alarm), .cond_to_line(cond_to_line), .cond_to_ip(cond_to_ip));
    t1_line_model t1_line_model_inst (.mclk(mclk), .reset(reset), .line_word(line_word), .line_valid(line_valid),
        .line_ready(line_ready), .stall(stall), .slow(slow), .got_word(got_word), .got_count(got_count));
    // clock and hang guard; the tests need a few hundred cycles
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    // word held until an edge that sees pkt_ready high
    task automatic push(input slot_word_type v);
        int n = 0;
        pkt_word = v;
        pkt_valid = 1;
        while (pkt_ready !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        tick(1);
        pkt_valid = 0;
    endtask : push
    task automatic next_word(output slot_word_type v);
        int c = got_count;
        int n = 0;
        while (got_count == c && n < 100) begin
            tick(1);
            n++;
        end
        check("line word arrival", n < 100, 1);
        v = got_word;
    endtask : next_word
    // one-cycle strobe; the word is inverted once released
    task automatic rx(input slot_word_type v, input logic [7:0] d, input logic [3:0] s);
        rx_word = v;
        rx_valid = 1;
        tick(1);
        rx_valid = 0;
        rx_word = ~v;
        check("ip_valid", ip_valid, 1);
        check("ip data", ip_word.data, d);
        check("ip sig", ip_word.sig, s);
    endtask : rx
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        cfg = '{line_mode: LINE_ESF, cas_enable: 1'b1, restore_long: 1'b0, idle_code: 8'h3C, cond_data: 8'hA5,
            cond_sig: 4'h6};
        tick(16);
        check("framer_cas at reset", framer_cas, 1);
        check("pkt_ready at reset", pkt_ready, 1);
        check("line_valid at reset", line_valid, 0);
        reset = 0;
        next_word(w);
        check("idle byte", w.data, 8'h3C);
        slot_used = 1;
        tick(3);
        push('{slot: 5'h03, sig: 4'h9, data: 8'h55});
        next_word(w);
        check("live word", w, {5'h03, 4'h9, 8'h55});
        buf_underrun = 1;
        tick(1);
        check("cond_to_line", cond_to_line, 1);
        push('{slot: 5'h04, sig: 4'h9, data: 8'h55});
        next_word(w);
        check("cond data esf", w.data, 8'hA5);
        check("cond sig esf", w.sig, 4'h6);
        {buf_underrun, buf_overrun} = 2'b01;
        cfg.line_mode = LINE_D4;
        tick(3);
        push('{slot: 5'h05, sig: 4'h9, data: 8'h55});
        next_word(w);
        check("cond data d4", w.data, 8'hA5);
        check("cond sig d4", w.sig, 4'h6 & SIG_AB_MASK);
        buf_overrun = 0;
        tick(3);
        check("cond_to_line off", cond_to_line, 0);
        push('{slot: 5'h06, sig: 4'h9, data: 8'h66});
        next_word(w);
        check("live after fault", w.data, 8'h66);
        cfg.cas_enable = 0;
        tick(3);
        check("framer_cas off", framer_cas, 0);
        check("framed", framer_framed, 1);
        cfg.cas_enable = 1;
        cfg.line_mode = LINE_UNFRAMED;
        buf_underrun = 1;
        tick(3);
        check("framer passthrough", framer_framed, 0);
        next_word(w);
        check("ais data", w.data, ALL_ONES);
        check("ais sig", w.sig, 4'hF);
        line_alarm_pin = 3'b010;
        tick(4);
        rx('{slot: 5'h02, sig: 4'h9, data: 8'h12}, 8'h12, 4'h9);
        line_alarm_pin = 3'b100;
        tick(4);
        rx('{slot: 5'h02, sig: 4'h9, data: 8'h12}, ALL_ONES, 4'h9);
        buf_underrun = 0;
        line_alarm_pin = '0;
        cfg.line_mode = LINE_ESF;
        tick(4);
        rx('{slot: 5'h01, sig: 4'h9, data: 8'h33}, 8'h33, 4'h9);
        tick(1);
        check("ip_valid one cycle", ip_valid, 0);
        for (int i = 0; i < 3; i++) begin
            line_alarm_pin = 3'b100 >> i;
            tick(4);
            check("cond_to_ip", cond_to_ip, 1);
            rx('{slot: 5'h01, sig: 4'h9, data: 8'h33}, 8'hA5, 4'h6);
        end
        // restore hold for both settings, sync latency allowed for
        for (int i = 0; i < 2; i++) begin
            cfg.restore_long = i[0];
            line_alarm_pin = 3'b010;
            tick(4);
            check("red alarm set", red_alarm, 1);
            line_alarm_pin = '0;
            h = 0;
            while (red_alarm === 1'b1 && h < 200) begin
                tick(1);
                h++;
            end
            check("restore hold", h >= (i ? LONG_N : SHORT_N) && h <= (i ? LONG_N : SHORT_N) + 4, 1);
        end
        stall = 1;
        k = 0;
        while (pkt_ready === 1'b1 && k < 40) begin
            pkt_word = '{slot: 5'h01, sig: 4'h0, data: 8'(k)};
            pkt_valid = 1;
            tick(1);
            k++;
        end
        pkt_valid = 0;
        check("fifo holds depth", k >= FIFO_DEPTH && k <= FIFO_DEPTH + 1, 1);
        {stall, slow} = 2'b01;
        for (int j = 0; j < k; j++) begin
            next_word(w);
            check("drain order", w.data, 8'(j));
        end
        check("pkt_ready after drain", pkt_ready, 1);
        final_report();
    end
endmodule : tb
